// File: hw/rtc_pkg.sv
/*
 * Constants shared by the real-time clock: register map, control
 * bits, timebase rates and alarm limits.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
package rtc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int             ADDR_W      = 8;
	localparam logic [7:0]     OFF_SECONDS = 8'h00;
	localparam logic [7:0]     OFF_SUBSEC  = 8'h04;
	localparam logic [7:0]     OFF_CTRL    = 8'h08;
	localparam logic [7:0]     OFF_TRIM    = 8'h0C;
	localparam logic [7:0]     OFF_TODIV   = 8'h10;
	localparam logic [7:0]     OFF_SSIV    = 8'h14;
	localparam logic [7:0]     OFF_STATUS  = 8'h18;
	localparam logic [7:0]     OFF_MASK    = 8'h1C;

	// ----------------------------------------------------------------
	// Control bits
	// ----------------------------------------------------------------
	localparam int             CTRL_W      = 10;
	localparam int             C_RUN       = 0;
	localparam int             C_EXTCLK    = 1;
	localparam int             C_TODEN     = 2;
	localparam int             C_SSEN      = 3;
	localparam int             C_TODREC    = 4;
	localparam int             C_SSREC     = 5;
	localparam int             C_CALEN     = 6;
	localparam int             C_KEEP      = 7;
	localparam int             C_TODWAKE   = 8;
	localparam int             C_SSWAKE    = 9;
	localparam logic [9:0]     CTRL_RST    = 10'h000;

	// Status and mask bits
	localparam int             ST_W        = 2;
	localparam int             ST_TOD      = 0;
	localparam int             ST_SS       = 1;

	// ----------------------------------------------------------------
	// Timebase and limits
	// ----------------------------------------------------------------
	localparam int             TB_HZ       = 32768;
	localparam int             SUB_HZ      = 4096;
	localparam int             PREDIV      = TB_HZ / SUB_HZ;
	localparam int             SUB_W       = 12;
	localparam int             TOD_W       = 20;
	localparam int             MAX_DAYS    = 12;
	localparam int             SEC_PER_DAY = 86400;
	localparam logic [19:0]    TOD_MAX     = 20'(MAX_DAYS * SEC_PER_DAY);
	localparam logic [31:0]    SS_MAX      = 32'(64'(TOD_MAX) * 64'(SUB_HZ));
	localparam logic [19:0]    PPM_ONE     = 20'hF4240;
	localparam logic [7:0]     TRIM_MAX    = 8'h7F;
	localparam logic [7:0]     TRIM_NEGMAX = 8'h81;

endpackage

// File: hw/rtc_timebase_if.sv
/*
 * Carrier between the clock core and its timebase.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface rtc_timebase_if;
	logic              useExt;
	logic              run;
	logic              calEn;
	logic signed [7:0] trim;
	logic              tick;
	logic              calOut;

	modport core (output useExt, output run, output calEn, output trim,
		input tick, input calOut);
	modport tb (input useExt, input run, input calEn, input trim,
		output tick, output calOut);
endinterface
`default_nettype wire

// File: hw/rtc_timebase.sv
/*
 * Timebase: synchronises the 32.768 kHz crystal and external clock
 * pins, applies the ppm trim and makes a 4096 Hz tick.
 * Assumes both pins are far slower than the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rtc_timebase #(
	parameter int PREDIV = rtc_pkg::PREDIV
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic xtalIn,
	input  wire logic extClkIn,
	rtc_timebase_if.tb tb
);
	localparam int PW = $clog2(PREDIV);

	generate
		if (PREDIV < 2 || (1 << PW) != PREDIV) begin : g_bad
			$error("PREDIV must be a power of two");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin synchronisers, three stages, level taken when two agree
	// ----------------------------------------------------------------
	logic [2:0]    xs_q, xs_d, es_q, es_d;
	logic          lvl_q, lvl_d;
	logic [19:0]   acc_q, acc_d;
	logic [PW-1:0] pre_q, pre_d;
	logic          tick_q, tick_d, cal_q, cal_d;
	logic          src2, src3, edgeSeen;
	logic [7:0]    mag;
	logic [20:0]   accSum;
	logic [PW:0]   preSum;
	logic [1:0]    step;

	// Next state for synchronisers, trim accumulator and prescaler
	always_comb begin
		xs_d = {xs_q[1:0], xtalIn};
		es_d = {es_q[1:0], extClkIn};
		src2 = tb.useExt ? es_q[1] : xs_q[1];
		src3 = tb.useExt ? es_q[2] : xs_q[2];
		lvl_d = (src2 == src3) ? src3 : lvl_q;
		edgeSeen = lvl_d & ~lvl_q & tb.run;
		mag = tb.trim[7] ? 8'(-tb.trim) : 8'(tb.trim);
		accSum = {1'b0, acc_q} + {13'h0000, mag};
		step = 2'h1;
		acc_d = acc_q;
		pre_d = pre_q;
		tick_d = 1'b0;
		preSum = {1'b0, pre_q};
		if (edgeSeen) begin
			// One extra or one fewer edge per million corrects ppm
			if (accSum >= {1'b0, rtc_pkg::PPM_ONE}) begin
				acc_d = 20'(accSum - {1'b0, rtc_pkg::PPM_ONE});
				step = tb.trim[7] ? 2'h0 : 2'h2;
			end else begin
				acc_d = accSum[19:0];
			end
			preSum = {1'b0, pre_q} + (PW+1)'(step);
			pre_d = preSum[PW-1:0];
			tick_d = preSum[PW];
		end
		cal_d = tb.calEn & pre_q[PW-1];
	end

	// Register stage
	always_ff @(posedge clock) begin
		if (!nrst) begin
			xs_q   <= 3'h0;
			es_q   <= 3'h0;
			lvl_q  <= 1'b0;
			acc_q  <= 20'h00000;
			pre_q  <= '0;
			tick_q <= 1'b0;
			cal_q  <= 1'b0;
		end else begin
			xs_q   <= xs_d;
			es_q   <= es_d;
			lvl_q  <= lvl_d;
			acc_q  <= acc_d;
			pre_q  <= pre_d;
			tick_q <= tick_d;
			cal_q  <= cal_d;
		end
	end

	assign tb.tick   = tick_q;
	assign tb.calOut = cal_q;
endmodule
`default_nettype wire

// File: hw/rtc_core.sv
/*
 * Real-time clock top: APB register file, seconds and sub-second
 * counters, two alarms, interrupt and wake outputs.
 * Assumes a 40 MHz system clock and a 32.768 kHz timebase pin.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Seconds are kept as a plain 32-bit count; software converts to calendar.
// - Time-of-day alarm interval is programmable from 1 second to 12 days.
// - Independent 32-bit sub-second alarm in 1/4096 s steps, 244 us to 12 days.
// - Each alarm can be set to recur on its own.
// - An expired enabled alarm can raise the interrupt or wake the system.
// - Timebase comes from the crystal pin or the external clock pin.
// - Software trim adjusts rate by up to 127 ppm in 1 ppm steps.
// - When enabled, a pin carries a clock-derived signal for measuring.
// - Software can keep the clock running through the storage power state.
module rtc_core (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        xtalIn,
	input  wire logic        extClkIn,
	input  wire logic        storageMode,
	output logic             calClockOutput,
	output logic             keepPower,
	output logic             irq,
	output logic             wakeup
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0]                 secs_q, secs_d;
	logic [rtc_pkg::SUB_W-1:0]   sub_q, sub_d;
	logic [rtc_pkg::CTRL_W-1:0]  ctrl_q, ctrl_d;
	logic signed [7:0]           trim_q, trim_d;
	logic [rtc_pkg::TOD_W-1:0]   todIv_q, todIv_d, todRem_q, todRem_d;
	logic [31:0]                 ssIv_q, ssIv_d, ssRem_q, ssRem_d;
	logic                        todArm_q, todArm_d, ssArm_q, ssArm_d;
	logic [rtc_pkg::ST_W-1:0]    stat_q, stat_d, mask_q, mask_d;
	logic [31:0]                 prdata_q, prdata_d;

	logic        run, tick, secTick, todFire, ssFire;
	logic        setup, wrEn, hit;
	logic [31:0] rdata;
	logic [rtc_pkg::TOD_W-1:0] todNew;
	logic [31:0] ssNew;
	logic [7:0]  trimNew;

	rtc_timebase_if tbi ();

	rtc_timebase u_timebase (
		.clock    (clock),
		.nrst     (nrst),
		.xtalIn   (xtalIn),
		.extClkIn (extClkIn),
		.tb       (tbi)
	);

	// ----------------------------------------------------------------
	// Timebase control
	// ----------------------------------------------------------------
	// Counting stops in storage unless software kept the clock alive
	assign run = ctrl_q[rtc_pkg::C_RUN] & (~storageMode | ctrl_q[rtc_pkg::C_KEEP]);
	assign keepPower   = ctrl_q[rtc_pkg::C_RUN] & ctrl_q[rtc_pkg::C_KEEP];
	assign tbi.run    = run;
	assign tbi.useExt = ctrl_q[rtc_pkg::C_EXTCLK];
	assign tbi.calEn  = ctrl_q[rtc_pkg::C_CALEN];
	assign tbi.trim   = trim_q;
	assign calClockOutput = tbi.calOut;

	assign tick    = tbi.tick & run;
	assign secTick = tick & (sub_q == {rtc_pkg::SUB_W{1'b1}});

	// Alarm expiry on the last count of the interval
	assign todFire = todArm_q & ctrl_q[rtc_pkg::C_TODEN] & secTick
		& (todRem_q == 20'h00001);
	assign ssFire  = ssArm_q & ctrl_q[rtc_pkg::C_SSEN] & tick
		& (ssRem_q == 32'h0000_0001);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup  = psel & ~penable;
	assign wrEn   = psel & penable & pwrite & hit;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_q;

	// Address decode and read mux
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr)
			rtc_pkg::OFF_SECONDS: rdata = secs_q;
			rtc_pkg::OFF_SUBSEC:  rdata = {20'h00000, sub_q};
			rtc_pkg::OFF_CTRL:    rdata = {22'h000000, ctrl_q};
			rtc_pkg::OFF_TRIM:    rdata = {{24{trim_q[7]}}, trim_q};
			rtc_pkg::OFF_TODIV:   rdata = {12'h000, todIv_q};
			rtc_pkg::OFF_SSIV:    rdata = ssIv_q;
			rtc_pkg::OFF_STATUS:  rdata = {30'h0000_0000, stat_q};
			rtc_pkg::OFF_MASK:    rdata = {30'h0000_0000, mask_q};
			default:              hit = 1'b0;
		endcase
	end

	// Interval clamps keep alarms inside their documented span
	always_comb begin
		if (pwdata == 32'h0000_0000) begin
			todNew = 20'h00001;
		end else if (pwdata > {12'h000, rtc_pkg::TOD_MAX}) begin
			todNew = rtc_pkg::TOD_MAX;
		end else begin
			todNew = pwdata[rtc_pkg::TOD_W-1:0];
		end
		if (pwdata == 32'h0000_0000) begin
			ssNew = 32'h0000_0001;
		end else if (pwdata > rtc_pkg::SS_MAX) begin
			ssNew = rtc_pkg::SS_MAX;
		end else begin
			ssNew = pwdata;
		end
		trimNew = (pwdata[7:0] == 8'h80) ? rtc_pkg::TRIM_NEGMAX : pwdata[7:0];
	end

	// ----------------------------------------------------------------
	// Next state of counters, alarms and registers
	// ----------------------------------------------------------------
	always_comb begin
		secs_d   = secs_q;
		sub_d    = sub_q;
		ctrl_d   = ctrl_q;
		trim_d   = trim_q;
		todIv_d  = todIv_q;
		ssIv_d   = ssIv_q;
		todRem_d = todRem_q;
		ssRem_d  = ssRem_q;
		todArm_d = todArm_q;
		ssArm_d  = ssArm_q;
		mask_d   = mask_q;
		prdata_d = prdata_q;
		// Free-running counters
		if (tick) begin
			sub_d = sub_q + 12'h001;
		end
		if (secTick) begin
			secs_d = secs_q + 32'h0000_0001;
		end
		// Time-of-day alarm counts seconds
		if (todArm_q & ctrl_q[rtc_pkg::C_TODEN] & secTick) begin
			todRem_d = todRem_q - 20'h00001;
		end
		if (todFire) begin
			if (ctrl_q[rtc_pkg::C_TODREC]) begin
				todRem_d = todIv_q;
			end else begin
				todArm_d = 1'b0;
			end
		end
		// Sub-second alarm counts 4096 Hz ticks
		if (ssArm_q & ctrl_q[rtc_pkg::C_SSEN] & tick) begin
			ssRem_d = ssRem_q - 32'h0000_0001;
		end
		if (ssFire) begin
			if (ctrl_q[rtc_pkg::C_SSREC]) begin
				ssRem_d = ssIv_q;
			end else begin
				ssArm_d = 1'b0;
			end
		end
		// Sticky flags: hardware set wins over a write-one clear
		stat_d = stat_q;
		if (wrEn && paddr == rtc_pkg::OFF_STATUS) begin
			stat_d = stat_q & ~pwdata[rtc_pkg::ST_W-1:0];
		end
		if (todFire) begin
			stat_d[rtc_pkg::ST_TOD] = 1'b1;
		end
		if (ssFire) begin
			stat_d[rtc_pkg::ST_SS] = 1'b1;
		end
		// Software writes take effect at the access edge
		if (wrEn) begin
			unique case (paddr)
				rtc_pkg::OFF_SECONDS: secs_d = pwdata;
				rtc_pkg::OFF_SUBSEC:  sub_d = pwdata[rtc_pkg::SUB_W-1:0];
				rtc_pkg::OFF_CTRL: begin
					ctrl_d = pwdata[rtc_pkg::CTRL_W-1:0];
					// Enabling an alarm restarts its interval
					if (pwdata[rtc_pkg::C_TODEN] & ~ctrl_q[rtc_pkg::C_TODEN]) begin
						todRem_d = todIv_q;
						todArm_d = 1'b1;
					end
					if (pwdata[rtc_pkg::C_SSEN] & ~ctrl_q[rtc_pkg::C_SSEN]) begin
						ssRem_d = ssIv_q;
						ssArm_d = 1'b1;
					end
				end
				rtc_pkg::OFF_TRIM:    trim_d = trimNew;
				rtc_pkg::OFF_TODIV: begin
					todIv_d  = todNew;
					todRem_d = todNew;
					todArm_d = 1'b1;
				end
				rtc_pkg::OFF_SSIV: begin
					ssIv_d  = ssNew;
					ssRem_d = ssNew;
					ssArm_d = 1'b1;
				end
				rtc_pkg::OFF_MASK:    mask_d = pwdata[rtc_pkg::ST_W-1:0];
				default: begin
				end
			endcase
		end
		// Read data is captured in the setup cycle
		if (setup & ~pwrite) begin
			prdata_d = rdata;
		end
	end

	// Register stage
	always_ff @(posedge clock) begin
		if (!nrst) begin
			secs_q   <= 32'h0000_0000;
			sub_q    <= 12'h000;
			ctrl_q   <= rtc_pkg::CTRL_RST;
			trim_q   <= 8'sh00;
			todIv_q  <= 20'h00001;
			ssIv_q   <= 32'h0000_0001;
			todRem_q <= 20'h00001;
			ssRem_q  <= 32'h0000_0001;
			todArm_q <= 1'b0;
			ssArm_q  <= 1'b0;
			stat_q   <= 2'h0;
			mask_q   <= 2'h0;
			prdata_q <= 32'h0000_0000;
		end else begin
			secs_q   <= secs_d;
			sub_q    <= sub_d;
			ctrl_q   <= ctrl_d;
			trim_q   <= trim_d;
			todIv_q  <= todIv_d;
			ssIv_q   <= ssIv_d;
			todRem_q <= todRem_d;
			ssRem_q  <= ssRem_d;
			todArm_q <= todArm_d;
			ssArm_q  <= ssArm_d;
			stat_q   <= stat_d;
			mask_q   <= mask_d;
			prdata_q <= prdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and wake
	// ----------------------------------------------------------------
	assign irq    = |(stat_q & mask_q);
	assign wakeup = |(stat_q & {ctrl_q[rtc_pkg::C_SSWAKE],
		ctrl_q[rtc_pkg::C_TODWAKE]});
endmodule
`default_nettype wire

// File: test/rtc_core_assertions.sv
/*
 * Port checker for the real-time clock: bus answers, read data hold,
 * interrupt, wake, power-keep and calibration output relations.
 * Assumes it is bound to rtc_core and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module rtc_core_checker (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        xtalIn,
	input wire logic        extClkIn,
	input wire logic        storageMode,
	input wire logic        calClockOutput,
	input wire logic        keepPower,
	input wire logic        irq,
	input wire logic        wakeup
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic acc;
	logic wrCtrl;
	logic mapped;

	// Decoded bus phases
	assign acc    = psel && penable;
	assign wrCtrl = acc && pwrite && paddr == rtc_pkg::OFF_CTRL;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= rtc_pkg::OFF_MASK;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	bus_ready_a: assert property (acc |-> pready)
		else $error("access phase without ready");
	bad_addr_a: assert property (acc |-> pslverr == !mapped)
		else $error("slave error does not match address decode");
	read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved outside a read setup");
	mask_off_a: assert property (acc && pwrite && paddr == rtc_pkg::OFF_MASK
		&& pwdata[1:0] == 2'h0 |=> !irq)
		else $error("interrupt high with all sources masked");
	wake_off_a: assert property (wrCtrl && pwdata[9:8] == 2'h0 |=> !wakeup)
		else $error("wake high with both wake enables off");
	keep_on_a: assert property (wrCtrl && pwdata[7] && pwdata[0] |=> keepPower)
		else $error("power keep low although requested");
	keep_off_a: assert property (wrCtrl && !pwdata[7] |=> !keepPower)
		else $error("power keep high although not requested");
	cal_off_a: assert property (wrCtrl && !pwdata[6] |-> ##2 !calClockOutput)
		else $error("calibration output runs while disabled");
	reset_idle_a: assert property (disable iff (1'b0)
		!nrst |=> !irq && !wakeup && !keepPower && !calClockOutput)
		else $error("outputs not idle after reset");

	// Main scenarios reached
	cover property (!irq ##1 irq);
	cover property (!wakeup ##1 wakeup);
	cover property (!calClockOutput ##1 calClockOutput);
	cover property (acc && pslverr);
endmodule

bind rtc_core rtc_core_checker rtc_core_checker_i (.clock, .nrst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .xtalIn, .extClkIn, .storageMode,
	.calClockOutput, .keepPower, .irq, .wakeup);
`default_nettype wire

// File: test/test_rtc_core.sv
/*
 * Directed testbench for the real-time clock over APB.
 * Assumes the default timebase prescaler of eight rising pin edges per tick.
 */
`timescale 1ns/1ps
`default_nettype none
module test_rtc_core;
	logic        clock, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic        xtalIn, extClkIn, storageMode, calClockOutput, keepPower, irq, wakeup;
	logic        xtalOn, extOn;
	logic [2:0]  pinDiv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	int          n_fail, num_checks, n;
	logic [7:0]  ta [0:6] = '{rtc_pkg::OFF_TRIM, rtc_pkg::OFF_TRIM, rtc_pkg::OFF_TODIV,
		rtc_pkg::OFF_TODIV, rtc_pkg::OFF_SSIV, rtc_pkg::OFF_SSIV, rtc_pkg::OFF_SECONDS};
	logic [31:0] tw [0:6] = '{32'h80, 32'h7F, 32'h0, 32'hFFFFF, 32'h0, 32'hFFFFFFFF, 32'h12345678};
	logic [31:0] te [0:6] = '{32'hFFFFFF81, 32'h7F, 32'h1, 32'(rtc_pkg::TOD_MAX), 32'h1,
		rtc_pkg::SS_MAX, 32'h12345678};

	rtc_core rtc_core_i (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .xtalIn, .extClkIn, .storageMode, .calClockOutput, .keepPower,
		.irq, .wakeup);

	// 40 MHz system clock
	always #12.5 clock = ~clock;

	// Slow timebase pins, toggled every sixth clock while enabled
	always @(posedge clock) begin
		pinDiv <= (pinDiv == 3'h5) ? 3'h0 : pinDiv + 3'h1;
		if (pinDiv == 3'h5 && xtalOn) begin
			xtalIn <= ~xtalIn;
		end
		if (pinDiv == 3'h5 && extOn) begin
			extClkIn <= ~extClkIn;
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; read data and error taken at the ready edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		err = pslverr;
		if (k >= 20) begin
			n_fail++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check($sformatf("register %h", a), q, exp);
	endtask

	// Poll a register until all bits of m are set, bounded
	task automatic waitreg(input logic [7:0] a, input logic [31:0] m);
		int k;
		k = 0;
		q = 32'h0;
		while ((q & m) !== m && k < 400) begin
			xfer(1'b0, a, 32'h0);
			k++;
		end
		if ((q & m) !== m) begin
			n_fail++;
			print_verdict();
		end
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		{clock, nrst, psel, penable, pwrite, xtalIn, extClkIn, storageMode} = 8'h00;
		{xtalOn, extOn, pinDiv, paddr, pwdata, n_fail, num_checks} = '0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		xtalOn <= 1'b1;
		@(posedge clock);
		rd(rtc_pkg::OFF_CTRL, 32'h0);
		rd(rtc_pkg::OFF_STATUS, 32'h0);
		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, ta[i], tw[i]);
			rd(ta[i], te[i]);
		end
		xfer(1'b1, 8'h20, 32'h5A);
		rd(8'h20, 32'h0);
		check("bus error", 32'(err), 32'h1);
		$display("test registers done");
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h1);
		xfer(1'b1, rtc_pkg::OFF_SUBSEC, 32'hFFE);
		waitreg(rtc_pkg::OFF_SECONDS, 32'h1);
		check("seconds", q, 32'h12345679);
		rd(rtc_pkg::OFF_SUBSEC, 32'h0);
		$display("test seconds done");
		xfer(1'b1, rtc_pkg::OFF_MASK, 32'h3);
		xfer(1'b1, rtc_pkg::OFF_SSIV, 32'h2);
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h29);
		waitreg(rtc_pkg::OFF_STATUS, 32'h2);
		check("irq", 32'(irq), 32'h1);
		xfer(1'b1, rtc_pkg::OFF_STATUS, 32'h2);
		rd(rtc_pkg::OFF_STATUS, 32'h0);
		check("irq", 32'(irq), 32'h0);
		waitreg(rtc_pkg::OFF_STATUS, 32'h2);
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h09);
		xfer(1'b1, rtc_pkg::OFF_STATUS, 32'h3);
		waitreg(rtc_pkg::OFF_STATUS, 32'h2);
		xfer(1'b1, rtc_pkg::OFF_STATUS, 32'h3);
		repeat (400) @(posedge clock);
		rd(rtc_pkg::OFF_STATUS, 32'h0);
		xfer(1'b1, rtc_pkg::OFF_MASK, 32'h0);
		xfer(1'b1, rtc_pkg::OFF_SSIV, 32'h2);
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h209);
		waitreg(rtc_pkg::OFF_STATUS, 32'h2);
		check("wakeup", 32'(wakeup), 32'h1);
		check("irq", 32'(irq), 32'h0);
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h1);
		xfer(1'b1, rtc_pkg::OFF_STATUS, 32'h3);
		$display("test subsecond alarm done");
		xfer(1'b1, rtc_pkg::OFF_TODIV, 32'h1);
		xfer(1'b1, rtc_pkg::OFF_SUBSEC, 32'hFFD);
		xfer(1'b1, rtc_pkg::OFF_MASK, 32'h1);
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h5);
		waitreg(rtc_pkg::OFF_STATUS, 32'h1);
		check("irq", 32'(irq), 32'h1);
		xfer(1'b1, rtc_pkg::OFF_STATUS, 32'h1);
		xfer(1'b1, rtc_pkg::OFF_MASK, 32'h0);
		$display("test day alarm done");
		xtalOn <= 1'b0;
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h3);
		xfer(1'b1, rtc_pkg::OFF_SUBSEC, 32'h0);
		extOn <= 1'b1;
		waitreg(rtc_pkg::OFF_SUBSEC, 32'h2);
		extOn <= 1'b0;
		xtalOn <= 1'b1;
		storageMode <= 1'b1;
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h1);
		xfer(1'b1, rtc_pkg::OFF_SUBSEC, 32'h0);
		repeat (300) @(posedge clock);
		rd(rtc_pkg::OFF_SUBSEC, 32'h0);
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h81);
		check("keep power", 32'(keepPower), 32'h1);
		waitreg(rtc_pkg::OFF_SUBSEC, 32'h2);
		storageMode <= 1'b0;
		$display("test timebase and storage done");
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h41);
		n = 0;
		while (calClockOutput !== 1'b1 && n < 300) begin
			@(posedge clock);
			n++;
		end
		check("cal clock", 32'(calClockOutput), 32'h1);
		xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h1);
		$display("test calibration done");
		print_verdict();
	end
endmodule
`default_nettype wire
